// File: include/awe_pkg.sv
/*
  Package for the address window extender: widths, register offsets,
  reset values and the bus carrier structs.
  Assumes a single clock domain and a 32-bit classic Wishbone control bus.
*/
package awe_pkg;

  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int DATA_W = 32;
  localparam int SEL_W = DATA_W / 8;
  localparam int WIN_ADDR_W = 28;
  localparam int WIN_SEL_W = 2;
  localparam int WIN_OFS_W = WIN_ADDR_W - WIN_SEL_W;
  localparam int WINDOW_COUNT = 1 << WIN_SEL_W;
  localparam int EXP_ADDR_W = 32;
  localparam int BURST_W = 4;
  localparam int BASE_REG_W = 64;
  localparam int CTRL_ADDR_W = 8;

  // ----------------------------------------------------------------------
  // Register layout and reset values
  // ----------------------------------------------------------------------
  localparam logic [CTRL_ADDR_W-1:0] BASE_STRIDE = 8'h08;
  localparam logic [CTRL_ADDR_W-1:0] BASE_LO_OFS = 8'h00;
  localparam logic [CTRL_ADDR_W-1:0] BASE_HI_OFS = 8'h04;
  localparam logic [CTRL_ADDR_W-1:0] STATUS_OFS = 8'h40;
  localparam logic [BASE_REG_W-1:0] DEFAULT_BASE = 64'h0000_0000_0000_0000;
  localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [BURST_W-1:0] ONE_BEAT = 4'h1;
  localparam logic [SEL_W-1:0] ALL_LANES = 4'hF;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic read;
    logic write;
    logic [WIN_ADDR_W-1:0] addr;
    logic [SEL_W-1:0] byte_en;
    logic [BURST_W-1:0] burst;
    logic [DATA_W-1:0] wdata;
  } awe_win_req_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [EXP_ADDR_W-1:0] addr;
    logic [SEL_W-1:0] byte_en;
    logic [BURST_W-1:0] burst;
    logic [DATA_W-1:0] wdata;
  } awe_exp_req_t;

  typedef struct packed {
    logic wait_req;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
  } awe_rsp_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [CTRL_ADDR_W-1:0] adr;
    logic [SEL_W-1:0] sel;
    logic [DATA_W-1:0] dat;
  } awe_wb_req_t;

endpackage

// File: core/awe_base_regs.sv
/*
  Bank of 64-bit sub-window base registers behind a Wishbone slave.
  Assumes a classic Wishbone master that holds its request until ack.
*/
`timescale 1ns/1ps
module awe_base_regs #(
  parameter int COUNT = awe_pkg::WINDOW_COUNT,
  parameter bit CTRL_EN = 1'b1,
  parameter logic [awe_pkg::BASE_REG_W-1:0] RESET_BASE = awe_pkg::DEFAULT_BASE
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire awe_pkg::awe_wb_req_t wb_req,
  input wire logic [awe_pkg::DATA_W-1:0] status_word,
  output logic [awe_pkg::DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [COUNT-1:0][awe_pkg::BASE_REG_W-1:0] base
);

  typedef struct packed {
    logic [COUNT-1:0][awe_pkg::BASE_REG_W-1:0] base;
    logic ack;
    logic [awe_pkg::DATA_W-1:0] dat;
  } awe_regs_state_t;

  awe_regs_state_t st;
  awe_regs_state_t next_st;

  // ----------------------------------------------------------------------
  // Decode and update
  // ----------------------------------------------------------------------
  // A request is acked one cycle after it appears; ack then drops for a
  // cycle so a held request is never taken twice.
  always_comb begin
    logic take;
    logic [awe_pkg::CTRL_ADDR_W-1:0] ofs;
    logic [awe_pkg::DATA_W-1:0] rd;
    take = 1'b0;
    ofs = '0;
    rd = awe_pkg::ZERO_WORD;
    next_st = st;
    take = wb_req.cyc && wb_req.stb && !st.ack;
    next_st.ack = take;
    if (wb_req.adr == awe_pkg::STATUS_OFS) begin
      rd = status_word;
    end
    for (int i = 0; i < COUNT; i++) begin
      ofs = awe_pkg::CTRL_ADDR_W'(i) * awe_pkg::BASE_STRIDE;
      if (wb_req.adr == ofs + awe_pkg::BASE_LO_OFS) begin
        rd = st.base[i][awe_pkg::DATA_W-1:0];
        if (take && wb_req.we && CTRL_EN) begin
          for (int b = 0; b < awe_pkg::SEL_W; b++) begin
            if (wb_req.sel[b]) begin
              next_st.base[i][b*8 +: 8] = wb_req.dat[b*8 +: 8];
            end
          end
        end
      end
      if (wb_req.adr == ofs + awe_pkg::BASE_HI_OFS) begin
        rd = st.base[i][awe_pkg::BASE_REG_W-1:awe_pkg::DATA_W];
        if (take && wb_req.we && CTRL_EN) begin
          for (int b = 0; b < awe_pkg::SEL_W; b++) begin
            if (wb_req.sel[b]) begin
              next_st.base[i][awe_pkg::DATA_W + b*8 +: 8] =
                wb_req.dat[b*8 +: 8];
            end
          end
        end
      end
    end
    // Unmapped addresses are acked and read as zero.
    next_st.dat = take ? rd : awe_pkg::ZERO_WORD;
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st.base <= {COUNT{RESET_BASE}};
      st.ack <= 1'b0;
      st.dat <= awe_pkg::ZERO_WORD;
    end else begin
      st <= next_st;
    end
  end

  assign wb_dat_o = st.dat;
  assign wb_ack_o = st.ack;
  assign base = st.base;

endmodule

// File: core/awe_remap.sv
/*
  Combinational address translation: the select bits pick a base and
  the offset bits pass through.
  Assumes bases are aligned to the sub-window span by software.
*/
`timescale 1ns/1ps
module awe_remap #(
  parameter int COUNT = awe_pkg::WINDOW_COUNT
) (
  input wire logic [awe_pkg::WIN_ADDR_W-1:0] win_addr,
  input wire logic [COUNT-1:0][awe_pkg::BASE_REG_W-1:0] base,
  output logic [awe_pkg::EXP_ADDR_W-1:0] exp_addr
);

  // ----------------------------------------------------------------------
  // Translation
  // ----------------------------------------------------------------------
  // Equal sub-windows stacked by index; base bits inside the span are
  // dropped, so a misaligned base cannot corrupt the offset.
  always_comb begin
    logic [awe_pkg::WIN_SEL_W-1:0] idx;
    logic [awe_pkg::EXP_ADDR_W-1:0] b;
    idx = win_addr[awe_pkg::WIN_ADDR_W-1:awe_pkg::WIN_OFS_W];
    b = base[idx][awe_pkg::EXP_ADDR_W-1:0];
    exp_addr = {b[awe_pkg::EXP_ADDR_W-1:awe_pkg::WIN_OFS_W],
                win_addr[awe_pkg::WIN_OFS_W-1:0]};
  end

endmodule

// File: core/awe_top.sv
/*
  Address window extender top: windowed slave port, Wishbone control
  port and expanded master port.
  Assumes one clock, an upstream master that holds requests while
  wait_req is high, and downstream slaves that use wait and rvalid.
*/
// The register addresses and the Wishbone slave port were decided locally.
// Operation
// - Windowed address bits 27:26 choose the sub-window base register.
// - Bits 25:0 pass through unchanged as the offset in the sub-window.
// - A written base maps later accesses of that sub-window to it.
// - Sub-windows are equal in size and stacked by ascending index.
// - With control disabled the default mapping is fixed, not writable.
// - Reads of any burst length force all byte enables; writes keep their own.
// - A 4-bit burst count carries bursts of up to 15 words.
// - The 32-bit expanded byte address spans 4 GB downstream.
// - Windowed and control ports face upstream; expanded port downstream.
// - One 64-bit base register per sub-window, eight bytes apart.
// - Stored base replaces upper bits before the downstream request.
`timescale 1ns/1ps
module awe_top #(
  parameter bit CTRL_EN = 1'b1,
  parameter logic [awe_pkg::BASE_REG_W-1:0] RESET_BASE = awe_pkg::DEFAULT_BASE
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire awe_pkg::awe_win_req_t win_req,
  output awe_pkg::awe_rsp_t win_rsp,
  input wire awe_pkg::awe_wb_req_t wb_req,
  output logic [awe_pkg::DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  output awe_pkg::awe_exp_req_t exp_req,
  input wire awe_pkg::awe_rsp_t exp_rsp
);

  typedef struct packed {
    awe_pkg::awe_exp_req_t req;
    awe_pkg::awe_rsp_t rsp;
    logic busy;
  } awe_top_state_t;

  awe_top_state_t st;
  awe_top_state_t next_st;
  logic [awe_pkg::WINDOW_COUNT-1:0][awe_pkg::BASE_REG_W-1:0] base;
  logic [awe_pkg::EXP_ADDR_W-1:0] mapped;
  logic [awe_pkg::DATA_W-1:0] status_word;

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  // Status shows whether a downstream command is outstanding.
  assign status_word = {{(awe_pkg::DATA_W-1){1'b0}}, st.busy};

  awe_base_regs #(
    .COUNT(awe_pkg::WINDOW_COUNT),
    .CTRL_EN(CTRL_EN),
    .RESET_BASE(RESET_BASE)
  ) u_regs (
    .clk(clk),
    .rst_b(rst_b),
    .wb_req(wb_req),
    .status_word(status_word),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .base(base)
  );

  awe_remap #(
    .COUNT(awe_pkg::WINDOW_COUNT)
  ) u_remap (
    .win_addr(win_req.addr),
    .base(base),
    .exp_addr(mapped)
  );

  // ----------------------------------------------------------------------
  // Command path
  // ----------------------------------------------------------------------
  // One registered stage: an upstream command is captured while idle and
  // held on the expanded port until downstream wait drops. Upstream sees
  // wait high until that happens, so the command is taken exactly once.
  // The extra cycle of latency buys flop-driven outputs on both sides.
  always_comb begin
    next_st = st;
    next_st.rsp.rvalid = exp_rsp.rvalid;
    next_st.rsp.rdata = exp_rsp.rdata;
    if (st.busy) begin
      if (!exp_rsp.wait_req) begin
        next_st.busy = 1'b0;
        next_st.req.read = 1'b0;
        next_st.req.write = 1'b0;
        next_st.rsp.wait_req = 1'b0;
      end
    end else if (st.rsp.wait_req && (win_req.read || win_req.write)) begin
      next_st.busy = 1'b1;
      next_st.req.read = win_req.read;
      next_st.req.write = win_req.write;
      next_st.req.addr = mapped;
      next_st.req.burst = win_req.burst;
      next_st.req.wdata = win_req.wdata;
      // Reads of any burst length go downstream as one command, all lanes on.
      if (awe_pkg::BURST_W > 1 && win_req.read) begin
        next_st.req.byte_en = awe_pkg::ALL_LANES;
      end else begin
        next_st.req.byte_en = win_req.byte_en;
      end
    end else begin
      // Wait idles high so no command is taken before it is captured.
      next_st.rsp.wait_req = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st.req.read <= 1'b0;
      st.req.write <= 1'b0;
      st.req.addr <= '0;
      st.req.byte_en <= '0;
      st.req.burst <= awe_pkg::ONE_BEAT;
      st.req.wdata <= awe_pkg::ZERO_WORD;
      st.rsp.wait_req <= 1'b1;
      st.rsp.rvalid <= 1'b0;
      st.rsp.rdata <= awe_pkg::ZERO_WORD;
      st.busy <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // Upstream windowed port and downstream expanded port.
  assign exp_req = st.req;
  assign win_rsp = st.rsp;

endmodule

// File: verif/awe_top_checker.sv
/* Port checker for awe_top.
   Assumes one clock and masters that hold requests until answered. */
`timescale 1ns/1ps
module awe_top_checker (
  input wire logic clk,
  input wire logic rst_b,
  input wire awe_pkg::awe_win_req_t win_req,
  input wire awe_pkg::awe_rsp_t win_rsp,
  input wire awe_pkg::awe_wb_req_t wb_req,
  input wire logic [awe_pkg::DATA_W-1:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire awe_pkg::awe_exp_req_t exp_req,
  input wire awe_pkg::awe_rsp_t exp_rsp
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic go;
  // A downstream command is pending while either strobe is up.
  assign go = exp_req.read | exp_req.write;
  AST_ACK_LAT: assert property ($rose(wb_req.stb) |=> wb_ack_o)
    else $error("control ack late");
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("control ack too long");
  AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == '0)
    else $error("read data outside ack");
  AST_OFS: assert property (go |->
    exp_req.addr[25:0] == $past(win_req.addr[25:0]))
    else $error("offset changed");
  AST_BURST: assert property (go |->
    exp_req.burst == $past(win_req.burst))
    else $error("burst count changed");
  AST_LANES: assert property (exp_req.read |->
    exp_req.byte_en == awe_pkg::ALL_LANES)
    else $error("read lanes not all set");
  AST_HOLD: assert property (go && exp_rsp.wait_req |=>
    $stable(exp_req))
    else $error("command moved while stalled");
  AST_DONE: assert property (go && !exp_rsp.wait_req |=>
    !win_rsp.wait_req)
    else $error("accept not passed up");
  AST_WAIT_ONE: assert property (!win_rsp.wait_req |=>
    win_rsp.wait_req)
    else $error("wait low too long");
  AST_RDATA: assert property (exp_rsp.rvalid |=> win_rsp.rvalid &&
    win_rsp.rdata == $past(exp_rsp.rdata))
    else $error("read beat lost");
  AST_NO_RV: assert property (!exp_rsp.rvalid |=> !win_rsp.rvalid)
    else $error("spurious read beat");
endmodule
bind awe_top awe_top_checker u_chk (.clk(clk), .rst_b(rst_b),
  .win_req(win_req), .win_rsp(win_rsp), .wb_req(wb_req),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .exp_req(exp_req),
  .exp_rsp(exp_rsp));

// File: verif/awe_mem_model.sv
/* Downstream slave model on the expanded port.
   Assumes the bench changes its stall count only between commands. */
`timescale 1ns/1ps
module awe_mem_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire awe_pkg::awe_exp_req_t exp_req,
  input wire logic [3:0] delay,
  output awe_pkg::awe_rsp_t exp_rsp
);
  logic [3:0] cnt;
  logic [3:0] beats;
  logic [31:0] ptr;
  logic go;
  assign go = exp_req.read | exp_req.write;
  // Stalls delay+1 cycles, then returns one beat a cycle; idle data toggles
  // so a stale value can never pass for a fresh beat.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      exp_rsp <= '{1'b1, 1'b0, 32'h0000_0000};
      cnt <= 4'h0;
      beats <= 4'h0;
      ptr <= 32'h0000_0000;
    end else begin
      exp_rsp.wait_req <= !(go && cnt >= delay && exp_rsp.wait_req);
      cnt <= (go && exp_rsp.wait_req) ? cnt + 4'h1 : 4'h0;
      if (go && !exp_rsp.wait_req && exp_req.read) begin
        beats <= exp_req.burst;
        ptr <= exp_req.addr;
      end else if (beats != 4'h0) begin
        beats <= beats - 4'h1;
        ptr <= ptr + 32'h0000_0004;
      end
      exp_rsp.rvalid <= beats != 4'h0;
      exp_rsp.rdata <= (beats != 4'h0) ? ptr : ~exp_rsp.rdata;
    end
  end
endmodule

// File: verif/tb.sv
/* Self-checking bench for awe_top with a fixed-mapping twin.
   Assumes the bound checker and the slave model in this folder. */
`timescale 1ns/1ps
module tb;
  localparam logic [63:0] RB = 64'h0000_0001_3C00_0000;
  logic clk;
  logic rst_b;
  logic [3:0] delay;
  logic [31:0] q;
  logic [31:0] got;
  logic [31:0] gotf;
  logic [31:0] gotd;
  logic [3:0] gotb;
  int n_fail;
  int check_count;
  // Every base keeps its bits inside the sub-window span at zero.
  logic [31:0] bases [4] = '{32'h0000_0000, 32'hA000_0000,
    32'h5400_0000, 32'hFC00_0000};
  awe_pkg::awe_win_req_t win_req;
  awe_pkg::awe_rsp_t win_rsp;
  awe_pkg::awe_rsp_t fix_rsp;
  awe_pkg::awe_wb_req_t wb_req;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  awe_pkg::awe_exp_req_t exp_req;
  awe_pkg::awe_exp_req_t fix_exp;
  awe_pkg::awe_rsp_t exp_rsp;
  awe_top #(.CTRL_EN(1'b1), .RESET_BASE(RB)) uut (.clk(clk),
    .rst_b(rst_b), .win_req(win_req), .win_rsp(win_rsp), .wb_req(wb_req),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .exp_req(exp_req),
    .exp_rsp(exp_rsp));
  // The twin runs in lockstep; its base writes must have no effect.
  awe_top #(.CTRL_EN(1'b0), .RESET_BASE(RB)) uut_fix (.clk(clk),
    .rst_b(rst_b), .win_req(win_req), .win_rsp(fix_rsp), .wb_req(wb_req),
    .wb_dat_o(), .wb_ack_o(), .exp_req(fix_exp), .exp_rsp(exp_rsp));
  awe_mem_model mem (.clk(clk), .rst_b(rst_b), .exp_req(exp_req),
    .delay(delay), .exp_rsp(exp_rsp));
  always #4 clk = ~clk;
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic hang(input int i, input int lim);
    if (i >= lim) begin
      n_fail++;
      tally_and_finish();
    end
  endtask
  // One classic Wishbone cycle; read data lands in q at the ack edge.
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int i;
    wb_req <= '{1'b1, 1'b1, we, a, 4'hF, d};
    for (i = 0; i < 50 && wb_ack_o !== 1'b1; i++) @(posedge clk);
    hang(i, 50);
    q = wb_dat_o;
    wb_req.cyc <= 1'b0;
    wb_req.stb <= 1'b0;
    @(posedge clk);
  endtask
  // One windowed command; e is the expected downstream byte address.
  task automatic win(input logic wr, input logic [27:0] a,
      input logic [3:0] bl, input logic [31:0] e);
    int i;
    int n;
    // Unknown until captured, so a missed command cannot pass on stale data.
    got = 'x;
    gotf = 'x;
    gotd = 'x;
    gotb = 'x;
    win_req <= '{!wr, wr, a, 4'h3, bl, e};
    for (i = 0; i < 200 && win_rsp.wait_req !== 1'b0; i++) begin
      @(posedge clk);
      if ((exp_req.read | exp_req.write) && !exp_rsp.wait_req) begin
        got = exp_req.addr;
        gotf = fix_exp.addr;
        gotd = exp_req.wdata;
        gotb = exp_req.byte_en;
      end
    end
    hang(i, 200);
    win_req.read <= 1'b0;
    win_req.write <= 1'b0;
    chk(got, e);
    chk(gotf, {RB[31:26], a[25:0]});
    chk(gotd, e);
    chk(32'(gotb), wr ? 32'h0000_0003 : 32'h0000_000F);
    chk(32'(fix_rsp.wait_req), 32'h0000_0000);
    n = 0;
    for (i = 0; i < 100 && !wr && n < bl; i++) begin
      @(posedge clk);
      if (win_rsp.rvalid === 1'b1) begin
        chk(win_rsp.rdata, e + 32'(4 * n));
        n++;
      end
    end
    hang(i, 100);
    @(posedge clk);
  endtask
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    delay = 4'h0;
    win_req = '0;
    wb_req = '0;
    n_fail = 0;
    check_count = 0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    // Reset contents, status word and an unmapped place.
    for (int k = 0; k < 4; k++) begin
      wb(1'b0, 8'(8 * k), 32'h0000_0000);
      chk(q, RB[31:0]);
      wb(1'b0, 8'(8 * k + 4), 32'h0000_0000);
      chk(q, RB[63:32]);
    end
    wb(1'b0, awe_pkg::STATUS_OFS, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    wb(1'b0, 8'h80, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    win(1'b0, 28'h800_0040, 4'h1, {RB[31:26], 26'h40});
    // Program each window, then burst at the top of its span with stalls.
    for (int k = 0; k < 4; k++) begin
      wb(1'b1, 8'(8 * k), bases[k]);
      wb(1'b0, 8'(8 * k), 32'h0000_0000);
      chk(q, bases[k]);
      delay <= 4'(3 * k);
      win(1'b0, {2'(k), 26'h3FF_FFE0}, 4'h8,
        {bases[k][31:26], 26'h3FF_FFE0});
    end
    wb(1'b1, 8'h0C, 32'h1234_5678);
    wb(1'b0, 8'h0C, 32'h0000_0000);
    chk(q, 32'h1234_5678);
    win(1'b1, {2'h1, 26'h10}, 4'h1, 32'hA000_0010);
    win(1'b1, {2'h3, 26'h4}, 4'h1, 32'hFC00_0004);
    tally_and_finish();
  end
endmodule
